// ===== inc/adc_serial_port_defs.vh
`ifndef ADC_SERIAL_PORT_DEFS_VH
`define ADC_SERIAL_PORT_DEFS_VH

// conversion word
`define WORD_W          16
`define WORD_MSB        15
`define BIT_CNT_W       5
`define LAST_BIT_IDX    5'h0F
`define ALL_BITS        5'h10

// timing, in master clock cycles
`define CNT_W           4
`define MSB_LEAD_CYC    4'h2
`define TAIL_CYC        4'h8
`define CS_LEAD_CYC     4'h8
`define SYNC_LAT_CYC    4'h4

// pin synchroniser layout and reset values
`define PIN_MODE        2
`define PIN_CSN         1
`define PIN_SCLK        0
`define PIN_SYNC_RST    3'h2

// port sequencer states
`define ST_W            3
`define ST_IDLE         3'h0
`define ST_PRESENT      3'h1
`define ST_WAITCS       3'h2
`define ST_LEAD         3'h3
`define ST_SHIFT        3'h4
`define ST_TAIL         3'h5

`endif

// ===== verilog/word_buffer.v
`timescale 1ns/1ps
`include "adc_serial_port_defs.vh"

module word_buffer #(
  parameter WIDTH = `WORD_W
) (
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output wire             inReady,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:1];
  reg             wrPtr_reg;
  reg             rdPtr_reg;
  reg [1:0]       count_reg;

  wire push = inValid & inReady;
  wire pop  = outValid & outReady;

  assign inReady  = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData  = mem[rdPtr_reg];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
      mem[0]    <= {WIDTH{1'b0}};
      mem[1]    <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wrPtr_reg] <= inData;
        wrPtr_reg      <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule

// ===== verilog/adc_serial_output_port.v
`timescale 1ns/1ps
`include "adc_serial_port_defs.vh"

module adc_serial_output_port (
  input  wire                 core_clk,
  input  wire                 nrst,
  input  wire                 portModeSelect,
  input  wire                 chipSelectN,
  input  wire                 shiftClkIn,
  input  wire                 wordInValid,
  input  wire [`WORD_W-1:0]   wordInData,
  output wire                 wordInReady,
  input  wire                 conversionEndingSoon,
  output wire                 serialDataOut,
  output wire                 serialDataOutEn,
  output wire                 shiftClkOut,
  output wire                 shiftClkOutEn,
  output wire                 dataReadyN
);

  // pin synchronisers: stage one feeds stage two only
  reg  [2:0]              pinMeta_reg;
  reg  [2:0]              pinSync_reg;
  reg                     csPrev_reg;
  reg                     sclkPrev_reg;

  // port sequencer
  reg  [`ST_W-1:0]        state_reg;
  reg  [`ST_W-1:0]        state_next;
  reg  [`WORD_W-1:0]      shift_reg;
  reg  [`WORD_W-1:0]      shift_next;
  reg  [`BIT_CNT_W-1:0]   bitCnt_reg;
  reg  [`BIT_CNT_W-1:0]   bitCnt_next;
  reg  [`CNT_W-1:0]       cnt_reg;
  reg  [`CNT_W-1:0]       cnt_next;
  reg                     sclk_reg;
  reg                     sclk_next;
  reg                     readyN_reg;
  reg                     readyN_next;
  reg                     popReady;

  // output side of the two-entry buffer
  wire                    bufValid;
  wire [`WORD_W-1:0]      bufData;

  wire selfClocked = pinSync_reg[`PIN_MODE];
  wire csLow       = ~pinSync_reg[`PIN_CSN];
  wire sclkIn      = pinSync_reg[`PIN_SCLK];
  wire csFall      = csPrev_reg & csLow;
  wire extRise     = ~sclkPrev_reg & sclkIn;
  wire extFall     = sclkPrev_reg & ~sclkIn;

  // an unread word gives way to the next conversion only while cs is low
  wire dropWord    = csLow & conversionEndingSoon & (bitCnt_reg == {`BIT_CNT_W{1'b0}});

  // converter side can run ahead of a stalled reader by three words: two in the buffer, one in the shift register
  word_buffer #(
    .WIDTH    (`WORD_W)
  ) u_word_buffer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .inValid  (wordInValid),
    .inData   (wordInData),
    .inReady  (wordInReady),
    .outValid (bufValid),
    .outReady (popReady),
    .outData  (bufData)
  );

  // stage one is read by stage two and by nothing else
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_reg <= `PIN_SYNC_RST;
    end else begin
      pinMeta_reg <= {portModeSelect, chipSelectN, shiftClkIn};
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinSync_reg <= `PIN_SYNC_RST;
    end else begin
      pinSync_reg <= pinMeta_reg;
    end
  end

  // a select held low through reset still yields one clean fall
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      csPrev_reg <= 1'b0;
    end else begin
      csPrev_reg <= pinSync_reg[`PIN_CSN];
    end
  end

  // host clock rests low, so a zero reset gives no false edge
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= pinSync_reg[`PIN_SCLK];
    end
  end

  always @* begin
    state_next  = state_reg;
    shift_next  = shift_reg;
    bitCnt_next = bitCnt_reg;
    cnt_next    = cnt_reg;
    sclk_next   = sclk_reg;
    readyN_next = readyN_reg;
    popReady    = 1'b0;

    case (state_reg)
      `ST_IDLE: begin
        sclk_next = 1'b0;
        // buffer pops only here, so a word never overtakes one in flight
        popReady  = 1'b1;
        if (bufValid) begin
          // msb goes on the pin now, data-ready follows later
          shift_next  = bufData;
          bitCnt_next = {`BIT_CNT_W{1'b0}};
          cnt_next    = `MSB_LEAD_CYC - 4'h1;
          state_next  = `ST_PRESENT;
        end
      end

      `ST_PRESENT: begin
        // external mode needs no lead: the host owns the clock
        if (cnt_reg == {`CNT_W{1'b0}}) begin
          readyN_next = 1'b0;
          if (!selfClocked) begin
            state_next = `ST_SHIFT;
          end else if (csLow) begin
            state_next = `ST_SHIFT;
          end else begin
            state_next = `ST_WAITCS;
          end
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end

      `ST_WAITCS: begin
        // clock parked low until the select falls again
        sclk_next = 1'b0;
        if (!selfClocked) begin
          state_next = `ST_SHIFT;
        end else if (csFall) begin
          // part of the lead is already spent in the synchroniser
          cnt_next   = `CS_LEAD_CYC - `SYNC_LAT_CYC;
          state_next = `ST_LEAD;
        end
      end

      `ST_LEAD: begin
        // a cs rise during the lead waits for a fresh fall
        if (dropWord) begin
          readyN_next = 1'b1;
          state_next  = `ST_IDLE;
        end else if (!csLow) begin
          state_next = `ST_WAITCS;
        end else if (cnt_reg == {`CNT_W{1'b0}}) begin
          state_next = `ST_SHIFT;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end

      `ST_SHIFT: begin
        if (selfClocked) begin
          if (sclk_reg) begin
            // data moves on the falling half, host samples on the rise
            sclk_next  = 1'b0;
            shift_next = {shift_reg[`WORD_MSB-1:0], 1'b0};
          end else if (!csLow) begin
            // pause with clock low; a fresh cs fall restarts the lead
            state_next = `ST_WAITCS;
          end else begin
            sclk_next   = 1'b1;
            bitCnt_next = bitCnt_reg + 5'h01;
            if (bitCnt_reg == `LAST_BIT_IDX) begin
              cnt_next   = `TAIL_CYC - 4'h1;
              state_next = `ST_TAIL;
            end
          end
        end else begin
          // rises count bits, falls put the next bit on the pin
          sclk_next = 1'b0;
          if (dropWord) begin
            readyN_next = 1'b1;
            state_next  = `ST_IDLE;
          end else if (extRise && bitCnt_reg != `ALL_BITS) begin
            bitCnt_next = bitCnt_reg + 5'h01;
          end else if (extFall && bitCnt_reg == `ALL_BITS) begin
            readyN_next = 1'b1;
            state_next  = `ST_IDLE;
          end else if (extFall && bitCnt_reg != {`BIT_CNT_W{1'b0}}) begin
            shift_next = {shift_reg[`WORD_MSB-1:0], 1'b0};
          end
        end
      end

      `ST_TAIL: begin
        // clock rests low through the tail
        sclk_next = 1'b0;
        if (cnt_reg == {`CNT_W{1'b0}}) begin
          readyN_next = 1'b1;
          state_next  = `ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end

      default: begin
        // unused codes fall back to a quiet idle port
        state_next  = `ST_IDLE;
        sclk_next   = 1'b0;
        readyN_next = 1'b1;
      end
    endcase
  end

  // sequencer state
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= `ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // word being shifted, msb on the pin
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= {`WORD_W{1'b0}};
    end else begin
      shift_reg <= shift_next;
    end
  end

  // bits handed to the host so far
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= {`BIT_CNT_W{1'b0}};
    end else begin
      bitCnt_reg <= bitCnt_next;
    end
  end

  // lead and tail timer, master clock cycles
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= {`CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // own shift clock; low at rest so the first edge is a rise
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= sclk_next;
    end
  end

  // data-ready, idle high
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readyN_reg <= 1'b1;
    end else begin
      readyN_reg <= readyN_next;
    end
  end

  assign serialDataOut   = shift_reg[`WORD_MSB];

  // data enable follows the synced select, clock enable follows it in self-clocked mode only; both two cycles behind the pin
  assign serialDataOutEn = csLow;
  assign shiftClkOut     = sclk_reg;
  assign shiftClkOutEn   = selfClocked & csLow;
  assign dataReadyN      = readyN_reg;

endmodule

// ===== sim/adc_port_properties.sv
`timescale 1ns/1ps
module adc_port_properties (
  input wire core_clk,
  input wire nrst,
  input wire portModeSelect,
  input wire chipSelectN,
  input wire shiftClkIn,
  input wire conversionEndingSoon,
  input wire serialDataOut,
  input wire serialDataOutEn,
  input wire shiftClkOut,
  input wire shiftClkOutEn,
  input wire dataReadyN
);
  // raw pin, ahead of the synchroniser, so this errs towards quiet
  reg bitsSeen;
  always @(posedge core_clk or negedge nrst)
    if (!nrst) bitsSeen <= 1'b0;
    else if (dataReadyN) bitsSeen <= 1'b0;
    else if (shiftClkIn) bitsSeen <= 1'b1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence leadQuiet;
    !shiftClkOut [*6];
  endsequence
  sequence halfCycle;
    shiftClkOut ##1 !shiftClkOut;
  endsequence
  selfDrive_a: assert property ((portModeSelect && !chipSelectN) [*4] |-> shiftClkOutEn)
    else $error("shift clock not driven");
  extNoClk_a: assert property (!portModeSelect [*4] |-> !shiftClkOutEn)
    else $error("shift clock driven in external mode");
  halfRate_a: assert property ($rose(shiftClkOut) |-> halfCycle)
    else $error("shift clock high too long");
  floatHigh_a: assert property (chipSelectN [*4] |-> !serialDataOutEn && !shiftClkOutEn)
    else $error("output driven while deselected");
  driveLow_a: assert property (!chipSelectN [*4] |-> serialDataOutEn)
    else $error("data not driven while selected");
  msbLead_a: assert property ($fell(dataReadyN) |-> serialDataOut == $past(serialDataOut, 2))
    else $error("data moved before ready fell");
  tailEight_a: assert property ($rose(dataReadyN) && portModeSelect
    |-> $past(shiftClkOut, 8) && !$past(shiftClkOut, 7))
    else $error("ready rise not eight after last edge");
  csLead_a: assert property ($fell(chipSelectN) && !dataReadyN && portModeSelect
    |-> leadQuiet ##[1:5] shiftClkOut)
    else $error("first edge lead wrong");
  dropWord_a: assert property (conversionEndingSoon && !dataReadyN && !chipSelectN
    && !portModeSelect && !bitsSeen |-> ##[1:2] dataReadyN)
    else $error("unread word not dropped");
endmodule
bind adc_serial_output_port adc_port_properties chk_u (.core_clk, .nrst, .portModeSelect, .chipSelectN,
  .shiftClkIn, .conversionEndingSoon, .serialDataOut, .serialDataOutEn, .shiftClkOut, .shiftClkOutEn, .dataReadyN);

// ===== sim/host_reader.sv
`timescale 1ns/1ps
module host_reader (
  input  wire        selfMode,
  input  wire        frameGo,
  input  wire        clr,
  input  wire        sdoLine,
  input  wire        sclkLine,
  output reg         hostClk,
  output reg  [15:0] gotWord,
  output reg  [4:0]  gotBits
);
  integer i;
  wire    sampClk = selfMode ? sclkLine : hostClk;
  initial hostClk = 1'b0;
  // clock stands low between frames; 64 ns period
  always @(posedge frameGo) begin
    #3;
    for (i = 0; i < 16; i = i + 1) begin
      #32 hostClk = 1'b1;
      #32 hostClk = 1'b0;
    end
  end
  always @(posedge sampClk or posedge clr) begin
    if (clr) begin
      gotWord <= 16'h0000;
      gotBits <= 5'h00;
    end else begin
      gotWord <= {gotWord[14:0], sdoLine};
      gotBits <= gotBits + 5'h01;
    end
  end
endmodule

// ===== sim/adc_serial_output_port_bench.sv
`timescale 1ns/1ps
module adc_serial_output_port_bench;
  reg         core_clk, nrst, portModeSelect, chipSelectN;
  reg         wordInValid, conversionEndingSoon, frameGo, clr;
  reg  [15:0] wordInData;
  wire        shiftClkIn, wordInReady, serialDataOut, serialDataOutEn;
  wire        shiftClkOut, shiftClkOutEn, dataReadyN;
  wire [15:0] gotWord;
  wire [4:0]  gotBits;
  integer     errorCnt, compares;
  // released lines sit on pull-downs
  wire sdoLine  = serialDataOutEn ? serialDataOut : 1'b0;
  wire sclkLine = shiftClkOutEn ? shiftClkOut : 1'b0;
  adc_serial_output_port dut_u (.core_clk, .nrst, .portModeSelect, .chipSelectN, .shiftClkIn, .wordInValid,
    .wordInData, .wordInReady, .conversionEndingSoon, .serialDataOut, .serialDataOutEn, .shiftClkOut,
    .shiftClkOutEn, .dataReadyN);
  host_reader host_u (.selfMode(portModeSelect), .frameGo, .clr, .sdoLine, .sclkLine, .hostClk(shiftClkIn),
    .gotWord, .gotBits);
  always #4 core_clk = ~core_clk;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares = compares + 1;
    if (g !== e) begin
      errorCnt = errorCnt + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task bit1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task waitRdy(input logic lvl);
    integer n;
    n = 0;
    while (dataReadyN !== lvl && n < 3000) begin
      @(negedge core_clk);
      n = n + 1;
    end
    bit1("dataReadyN", lvl, dataReadyN);
  endtask
  task send(input logic [15:0] w);
    integer n;
    n = 0;
    wordInValid = 1'b1;
    wordInData  = w;
    while (wordInReady !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n = n + 1;
    end
    @(negedge core_clk);
    wordInValid = 1'b0;
    @(negedge core_clk);
  endtask
  task readWord(input logic [15:0] w);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    waitRdy(1'b0);
    frameGo = !portModeSelect;
    @(negedge core_clk);
    frameGo = 1'b0;
    waitRdy(1'b1);
    chk("word", w, gotWord);
    chk("bits", 16'h0010, {11'h000, gotBits});
  endtask
  task scenSelf;
    portModeSelect = 1'b1;
    chipSelectN    = 1'b0;
    repeat (4) @(negedge core_clk);
    bit1("clkEn", 1'b1, shiftClkOutEn);
    send(16'h8001);
    readWord(16'h8001);
  endtask
  task scenBuffer;
    chipSelectN = 1'b1;
    send(16'hC3A5);
    send(16'h0001);
    send(16'hFFFE);
    repeat (4) @(negedge core_clk);
    bit1("ready", 1'b0, wordInReady);
    bit1("sdoEn", 1'b0, serialDataOutEn);
    bit1("clkEn", 1'b0, shiftClkOutEn);
    chipSelectN = 1'b0;
    readWord(16'hC3A5);
    readWord(16'h0001);
    readWord(16'hFFFE);
    bit1("ready", 1'b1, wordInReady);
  endtask
  task scenExt;
    portModeSelect = 1'b0;
    chipSelectN    = 1'b1;
    repeat (4) @(negedge core_clk);
    bit1("sdoEn", 1'b0, serialDataOutEn);
    chipSelectN = 1'b0;
    send(16'h5AC3);
    bit1("clkEn", 1'b0, shiftClkOutEn);
    readWord(16'h5AC3);
  endtask
  task scenDrop;
    send(16'h1234);
    send(16'hABCD);
    waitRdy(1'b0);
    conversionEndingSoon = 1'b1;
    @(negedge core_clk);
    conversionEndingSoon = 1'b0;
    @(negedge core_clk);
    bit1("dropRdy", 1'b1, dataReadyN);
    readWord(16'hABCD);
  endtask
  task finish_test;
    if (errorCnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {core_clk, nrst, wordInValid, conversionEndingSoon, frameGo, clr} = 6'h00;
    {portModeSelect, chipSelectN, wordInData} = 18'h1_0000;
    errorCnt = 0;
    compares = 0;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    scenSelf;
    scenBuffer;
    scenExt;
    scenDrop;
    finish_test;
  end
  initial begin
    #400000;
    errorCnt = errorCnt + 1;
    finish_test;
  end
endmodule
